// File: design/rcrb_regs.vh
// register map constants for the radio configuration register bank
`ifndef RCRB_REGS_VH
`define RCRB_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RCRB_ADDR_MAIN_CONTROL 5'h00
`define RCRB_ADDR_AUTO_ACK 5'h01
`define RCRB_ADDR_RX_PIPE 5'h02
`define RCRB_ADDR_ADDR_WIDTH 5'h03
`define RCRB_ADDR_RETRANSMIT 5'h04
`define RCRB_ADDR_STATUS 5'h07

// ----------------------------------------
// serial commands, last bit index and pin idle levels
// ----------------------------------------
`define RCRB_CMD_READ 3'h0
`define RCRB_CMD_WRITE 3'h1
`define RCRB_LAST_BIT 3'h7
`define RCRB_PIN_IDLE 3'h4

// ----------------------------------------
// field positions
// ----------------------------------------
`define RCRB_BIT_MASK_RX 6
`define RCRB_BIT_MASK_TX 5
`define RCRB_BIT_MASK_RT 4
`define RCRB_BIT_CRC_EN 3
`define RCRB_BIT_CRC_LEN 2
`define RCRB_BIT_POWER 1
`define RCRB_BIT_ROLE 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RCRB_RST_MAIN_CONTROL 7'h08
`define RCRB_RST_AUTO_ACK 6'h3F
`define RCRB_RST_RX_PIPE 6'h03
`define RCRB_RST_ADDR_LEN 2'h3
`define RCRB_RST_RETRY_DELAY 4'h0
`define RCRB_RST_RETRY_COUNT 4'h3

// ----------------------------------------
// address width codes and timing
// ----------------------------------------
`define RCRB_AW_3 2'h1
`define RCRB_AW_4 2'h2
`define RCRB_AW_5 2'h3
`define RCRB_RETRY_STEP_US 250
`define RCRB_REF_CLK_MHZ 50

`endif

// File: design/rcrb_register_bank.v
// radio configuration register bank behind the serial host port
`timescale 1ns/1ns
`include "rcrb_regs.vh"

module rcrb_register_bank
#(
   parameter RETRY_STEP_CYCLES = `RCRB_RETRY_STEP_US * `RCRB_REF_CLK_MHZ
)
(
   input wire ref_clk,
   input wire rst_n,
   input wire spi_csn_n,
   input wire spi_sck,
   input wire spi_mosi,
   output reg spi_miso_out,
   output reg spi_miso_oe,
   input wire rx_data_ready_event,
   input wire tx_done_event,
   input wire retry_limit_event,
   input wire [2:0] rx_pipe_number,
   input wire tx_fifo_full,
   output reg irq_n,
   output reg crc_enable,
   output reg crc_length_select,
   output reg power_on_bit,
   output reg primary_role_select,
   output reg [5:0] auto_ack_enable_out,
   output reg [5:0] rx_pipe_enable_out,
   output reg [1:0] addr_len_field,
   output reg [4:0] addr_byte_used,
   output reg addr_len_illegal,
   output reg [3:0] retry_delay_field,
   output reg [17:0] retry_delay_cycles,
   output reg [3:0] retry_count_field,
   output reg retry_enabled
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam [2:0] PIN_IDLE = `RCRB_PIN_IDLE;
   wire [2:0] pin_raw = {spi_csn_n, spi_sck, spi_mosi};
   wire [2:0] pin_s;
   reg sck_prev;
   reg csn_prev;
   wire csn_s = pin_s[2];
   wire sck_s = pin_s[1];
   wire mosi_s = pin_s[0];
   wire sck_rise = sck_s & ~sck_prev;
   wire sck_fall = ~sck_s & sck_prev;
   wire frame_start = ~csn_s & csn_prev;

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : pin_sync
         // each stage resets to its pin's idle level, so no false edge follows reset
         reg [1:0] stage;
         always @(posedge ref_clk)
         begin
            if (!rst_n)
               stage <= {2{PIN_IDLE[g]}};
            else
               stage <= {stage[0], pin_raw[g]};
         end
         assign pin_s[g] = stage[1];
      end
   endgenerate

   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         sck_prev <= 1'b0;
         csn_prev <= 1'b1;
      end
      else
      begin
         sck_prev <= sck_s;
         csn_prev <= csn_s;
      end
   end

   // ----------------------------------------
   // register storage
   // ----------------------------------------
   reg [6:0] main_control;
   reg [5:0] auto_ack_enable;
   reg [5:0] rx_pipe_enable;
   reg [1:0] address_width_setup;
   reg [3:0] retry_delay;
   reg [3:0] retry_count;
   reg [2:0] irq_flags;

   // ----------------------------------------
   // serial frame state
   // ----------------------------------------
   reg [7:0] shift_in;
   reg [7:0] shift_out;
   reg [2:0] bit_cnt;
   reg first_byte;
   reg [7:0] cmd;
   reg write_done;
   reg load_pending;

   wire [7:0] rx_byte = {shift_in[6:0], mosi_s};
   wire byte_done = sck_rise & ~csn_s & (bit_cnt == `RCRB_LAST_BIT);
   wire is_write = (cmd[7:5] == `RCRB_CMD_WRITE);
   // only the first data byte of a write lands; trailing bytes are dropped
   wire do_write = byte_done & ~first_byte & is_write & ~write_done;
   wire [4:0] wr_addr = cmd[4:0];
   // crc enable is read back as forced whenever any pipe acknowledges
   wire crc_eff = main_control[`RCRB_BIT_CRC_EN] | (|auto_ack_enable);
   wire [7:0] status_byte = {1'b0, irq_flags, rx_pipe_number, tx_fifo_full};

   reg [7:0] rd_data_q;
   reg [7:0] rd_data;
   always @*
   begin
      rd_data = 8'h00;
      case (rx_byte[4:0])
         `RCRB_ADDR_MAIN_CONTROL: rd_data = {1'b0, main_control[6:4], crc_eff,
            main_control[2:0]};
         `RCRB_ADDR_AUTO_ACK: rd_data = {2'h0, auto_ack_enable};
         `RCRB_ADDR_RX_PIPE: rd_data = {2'h0, rx_pipe_enable};
         `RCRB_ADDR_ADDR_WIDTH: rd_data = {6'h00, address_width_setup};
         `RCRB_ADDR_RETRANSMIT: rd_data = {retry_delay, retry_count};
         `RCRB_ADDR_STATUS: rd_data = status_byte;
         default: rd_data = 8'h00;
      endcase
   end

   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         shift_in <= 8'h00;
         shift_out <= 8'h00;
         bit_cnt <= 3'h0;
         first_byte <= 1'b1;
         cmd <= 8'hFF;
         write_done <= 1'b0;
         load_pending <= 1'b0;
         spi_miso_out <= 1'b0;
         spi_miso_oe <= 1'b0;
      end
      else if (csn_s)
      begin
         bit_cnt <= 3'h0;
         first_byte <= 1'b1;
         cmd <= 8'hFF;
         write_done <= 1'b0;
         load_pending <= 1'b0;
         spi_miso_oe <= 1'b0;
      end
      else
      begin
         spi_miso_oe <= 1'b1;
         if (frame_start)
         begin
            // status goes out while the command byte comes in
            shift_out <= status_byte;
            spi_miso_out <= status_byte[7];
         end
         else if (sck_fall)
         begin
            if (load_pending)
            begin
               shift_out <= rd_data_q;
               spi_miso_out <= rd_data_q[7];
               load_pending <= 1'b0;
            end
            else
            begin
               shift_out <= {shift_out[6:0], 1'b0};
               spi_miso_out <= shift_out[6];
            end
         end
         if (sck_rise)
         begin
            shift_in <= rx_byte;
            bit_cnt <= bit_cnt + 3'h1;
         end
         if (byte_done)
         begin
            first_byte <= 1'b0;
            load_pending <= 1'b1;
            if (first_byte)
               cmd <= rx_byte;
            if (do_write)
               write_done <= 1'b1;
         end
      end
   end

   // read data is captured with the command so later register changes do not tear it
   always @(posedge ref_clk)
   begin
      if (!rst_n)
         rd_data_q <= 8'h00;
      else if (byte_done)
         rd_data_q <= (first_byte && rx_byte[7:5] == `RCRB_CMD_READ) ? rd_data : 8'h00;
   end

   // ----------------------------------------
   // register writes and flags
   // ----------------------------------------
   wire [2:0] flag_set = {rx_data_ready_event, tx_done_event, retry_limit_event};
   wire [2:0] flag_clr = (do_write && wr_addr == `RCRB_ADDR_STATUS) ? rx_byte[6:4] : 3'h0;

   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         main_control <= `RCRB_RST_MAIN_CONTROL;
         auto_ack_enable <= `RCRB_RST_AUTO_ACK;
         rx_pipe_enable <= `RCRB_RST_RX_PIPE;
         address_width_setup <= `RCRB_RST_ADDR_LEN;
         retry_delay <= `RCRB_RST_RETRY_DELAY;
         retry_count <= `RCRB_RST_RETRY_COUNT;
         irq_flags <= 3'h0;
      end
      else
      begin
         // set beats a simultaneous write-one clear
         irq_flags <= (irq_flags & ~flag_clr) | flag_set;
         if (do_write)
         begin
            // reserved bits are not stored, so they always read zero
            case (wr_addr)
               `RCRB_ADDR_MAIN_CONTROL: main_control <= rx_byte[6:0];
               `RCRB_ADDR_AUTO_ACK: auto_ack_enable <= rx_byte[5:0];
               `RCRB_ADDR_RX_PIPE: rx_pipe_enable <= rx_byte[5:0];
               `RCRB_ADDR_ADDR_WIDTH: address_width_setup <= rx_byte[1:0];
               `RCRB_ADDR_RETRANSMIT:
               begin
                  retry_delay <= rx_byte[7:4];
                  retry_count <= rx_byte[3:0];
               end
               // test addresses and the rest take no write, which blunts a stray 18h-1Bh access
               default: retry_count <= retry_count;
            endcase
         end
      end
   end

   // ----------------------------------------
   // decoded outputs
   // ----------------------------------------
   // the step is cut to the 18-bit delay width; sixteen default steps still fit
   wire [31:0] step_full = RETRY_STEP_CYCLES;
   wire [17:0] step_w = step_full[17:0];
   wire [17:0] delay_mult = {14'h0000, retry_delay} + 18'h00001;
   wire [35:0] delay_prod = delay_mult * step_w;

   reg [4:0] next_byte_used;
   always @*
   begin
      case (address_width_setup)
         `RCRB_AW_3: next_byte_used = 5'h07;
         `RCRB_AW_4: next_byte_used = 5'h0F;
         `RCRB_AW_5: next_byte_used = 5'h1F;
         default: next_byte_used = 5'h00;
      endcase
   end

   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         irq_n <= 1'b1;
         crc_enable <= 1'b1;
         crc_length_select <= 1'b0;
         power_on_bit <= 1'b0;
         primary_role_select <= 1'b0;
         auto_ack_enable_out <= `RCRB_RST_AUTO_ACK;
         rx_pipe_enable_out <= `RCRB_RST_RX_PIPE;
         addr_len_field <= `RCRB_RST_ADDR_LEN;
         addr_byte_used <= 5'h1F;
         addr_len_illegal <= 1'b0;
         retry_delay_field <= `RCRB_RST_RETRY_DELAY;
         retry_delay_cycles <= step_w;
         retry_count_field <= `RCRB_RST_RETRY_COUNT;
         retry_enabled <= 1'b1;
      end
      else
      begin
         irq_n <= ~|(irq_flags & ~main_control[`RCRB_BIT_MASK_RX:`RCRB_BIT_MASK_RT]);
         crc_enable <= crc_eff;
         crc_length_select <= main_control[`RCRB_BIT_CRC_LEN];
         power_on_bit <= main_control[`RCRB_BIT_POWER];
         primary_role_select <= main_control[`RCRB_BIT_ROLE];
         auto_ack_enable_out <= auto_ack_enable;
         rx_pipe_enable_out <= rx_pipe_enable;
         addr_len_field <= address_width_setup;
         addr_byte_used <= next_byte_used;
         addr_len_illegal <= (address_width_setup == 2'h0);
         retry_delay_field <= retry_delay;
         retry_delay_cycles <= delay_prod[17:0];
         retry_count_field <= retry_count;
         retry_enabled <= |retry_count;
      end
   end

endmodule // rcrb_register_bank

// File: sim/rcrb_register_bank_monitor.sv
// port checker for the radio configuration register bank
`timescale 1ns/1ns
module rcrb_register_bank_monitor
#(
   parameter RETRY_STEP_CYCLES = 12500
)
(
   input wire ref_clk,
   input wire rst_n,
   input wire spi_miso_oe,
   input wire rx_data_ready_event,
   input wire tx_done_event,
   input wire retry_limit_event,
   input wire irq_n,
   input wire crc_enable,
   input wire power_on_bit,
   input wire [5:0] auto_ack_enable_out,
   input wire [5:0] rx_pipe_enable_out,
   input wire [1:0] addr_len_field,
   input wire [4:0] addr_byte_used,
   input wire addr_len_illegal,
   input wire [3:0] retry_delay_field,
   input wire [17:0] retry_delay_cycles,
   input wire [3:0] retry_count_field,
   input wire retry_enabled
);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   reset_values_a: assert property ($rose(rst_n) |-> irq_n && crc_enable && !power_on_bit
      && auto_ack_enable_out == 6'h3F && rx_pipe_enable_out == 6'h03 && addr_len_field == 2'h3)
      else $error("reset values wrong");
   crc_forced_a: assert property (|auto_ack_enable_out && $stable(auto_ack_enable_out)
      |-> crc_enable) else $error("crc not forced on");
   // a mask change written over the port can also pull the pin low
   irq_cause_a: assert property ($fell(irq_n) |-> spi_miso_oe
      || $past(rx_data_ready_event | tx_done_event | retry_limit_event, 2))
      else $error("irq without cause");
   byte_used_a: assert property (addr_byte_used == (addr_len_field == 2'h1 ? 5'h07 :
      addr_len_field == 2'h2 ? 5'h0F : addr_len_field == 2'h3 ? 5'h1F : 5'h00))
      else $error("address bytes wrong");
   width_illegal_a: assert property (addr_len_illegal == (addr_len_field == 2'h0))
      else $error("illegal width flag wrong");
   retry_delay_a: assert property (
      retry_delay_cycles == (retry_delay_field + 32'h1) * RETRY_STEP_CYCLES)
      else $error("retry delay wrong");
   retry_enable_a: assert property (retry_enabled == (retry_count_field != 4'h0))
      else $error("retry enable wrong");
   config_change_a: assert property ($changed(power_on_bit) |-> spi_miso_oe)
      else $error("control changed outside a frame");
endmodule // rcrb_register_bank_monitor

bind rcrb_register_bank rcrb_register_bank_monitor #(.RETRY_STEP_CYCLES(RETRY_STEP_CYCLES)) mon_i
(
   .ref_clk(ref_clk),
   .rst_n(rst_n),
   .spi_miso_oe(spi_miso_oe),
   .rx_data_ready_event(rx_data_ready_event),
   .tx_done_event(tx_done_event),
   .retry_limit_event(retry_limit_event),
   .irq_n(irq_n),
   .crc_enable(crc_enable),
   .power_on_bit(power_on_bit),
   .auto_ack_enable_out(auto_ack_enable_out),
   .rx_pipe_enable_out(rx_pipe_enable_out),
   .addr_len_field(addr_len_field),
   .addr_byte_used(addr_byte_used),
   .addr_len_illegal(addr_len_illegal),
   .retry_delay_field(retry_delay_field),
   .retry_delay_cycles(retry_delay_cycles),
   .retry_count_field(retry_count_field),
   .retry_enabled(retry_enabled)
);

// File: sim/rcrb_host_model.sv
// host serial master model for the register bank port
`timescale 1ns/1ns
module rcrb_host_model
(
   output logic spi_csn_n,
   output logic spi_sck,
   output logic spi_mosi,
   input wire logic spi_miso_out,
   input wire logic spi_miso_oe
);
   initial
   begin
      spi_csn_n = 1'b1;
      spi_sck = 1'b0;
      spi_mosi = 1'b0;
   end
   // one whole 16-bit frame; sck idles low at both csn edges
   // offset of 7 ns keeps every edge away from the core clock edge
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [15:0] rx);
      logic [15:0] sh;
      integer i;
      begin
         sh = {cmd, wd};
         #7 spi_csn_n = 1'b0;
         #200;
         for (i = 0; i < 16; i++)
         begin
            spi_mosi = sh[15 - i];
            #80 spi_sck = 1'b1;
            #80 rx[15 - i] = spi_miso_oe ? spi_miso_out : 1'bx;
            spi_sck = 1'b0;
         end
         #80 spi_csn_n = 1'b1;
         // deselected line toggles so a stale bit is never taken as driven
         spi_mosi = ~spi_mosi;
         #193;
      end
   endtask
endmodule // rcrb_host_model

// File: sim/rcrb_register_bank_tb.sv
// self-checking bench for the radio configuration register bank
`timescale 1ns/1ns
`include "rcrb_regs.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module rcrb_register_bank_tb;
   typedef struct packed {logic [4:0] a; logic [7:0] wd; logic [7:0] rd; logic [7:0] pv;} rcrb_row_t;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] ev = 3'h0;
   logic [2:0] rx_pipe_number = 3'h5;
   logic tx_fifo_full = 1'b1;
   wire spi_csn_n, spi_sck, spi_mosi, spi_miso_out, spi_miso_oe, irq_n, crc_enable;
   wire crc_length_select, power_on_bit, primary_role_select, addr_len_illegal, retry_enabled;
   wire [5:0] auto_ack_enable_out, rx_pipe_enable_out;
   wire [1:0] addr_len_field;
   wire [4:0] addr_byte_used;
   wire [3:0] retry_delay_field, retry_count_field;
   integer bad_count = 0;
   integer checked = 0;
   integer i, k;
   logic [15:0] rx;
   logic [7:0] rstv [0:4] = '{8'h08, 8'h3F, 8'h03, 8'h03, 8'h03};
   // reserved fields always written as zero
   rcrb_row_t rows [0:11] = '{'{5'h00, 8'h7E, 8'h7E, 8'h0E}, '{5'h01, 8'h00, 8'h00, 8'h00},
      '{5'h00, 8'h01, 8'h01, 8'h01}, '{5'h01, 8'h21, 8'h21, 8'h21}, '{5'h00, 8'h01, 8'h09, 8'h09},
      '{5'h02, 8'h2A, 8'h2A, 8'h2A}, '{5'h03, 8'h01, 8'h01, 8'h39}, '{5'h03, 8'h02, 8'h02, 8'h7A},
      '{5'h03, 8'h00, 8'h00, 8'h04}, '{5'h03, 8'h03, 8'h03, 8'hFB}, '{5'h04, 8'hF0, 8'hF0, 8'hF0},
      '{5'h04, 8'h0F, 8'h0F, 8'h0F}};
   always #10 ref_clk = ~ref_clk;
   rcrb_register_bank #(.RETRY_STEP_CYCLES(10)) rcrb_register_bank_i (.ref_clk(ref_clk),
      .rst_n(rst_n), .spi_csn_n(spi_csn_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
      .spi_miso_out(spi_miso_out), .spi_miso_oe(spi_miso_oe), .rx_data_ready_event(ev[2]),
      .tx_done_event(ev[1]), .retry_limit_event(ev[0]), .rx_pipe_number(rx_pipe_number),
      .tx_fifo_full(tx_fifo_full), .irq_n(irq_n), .crc_enable(crc_enable),
      .crc_length_select(crc_length_select), .power_on_bit(power_on_bit),
      .primary_role_select(primary_role_select), .auto_ack_enable_out(auto_ack_enable_out),
      .rx_pipe_enable_out(rx_pipe_enable_out), .addr_len_field(addr_len_field),
      .addr_byte_used(addr_byte_used), .addr_len_illegal(addr_len_illegal),
      .retry_delay_field(retry_delay_field), .retry_delay_cycles(),
      .retry_count_field(retry_count_field), .retry_enabled(retry_enabled));
   rcrb_host_model rcrb_host_model_i (.spi_csn_n(spi_csn_n), .spi_sck(spi_sck),
      .spi_mosi(spi_mosi), .spi_miso_out(spi_miso_out), .spi_miso_oe(spi_miso_oe));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic [7:0] port_view(input [4:0] a);
      case (a)
         5'h00: port_view = {4'h0, crc_enable, crc_length_select, power_on_bit, primary_role_select};
         5'h01: port_view = {2'h0, auto_ack_enable_out};
         5'h02: port_view = {2'h0, rx_pipe_enable_out};
         5'h03: port_view = {addr_byte_used, addr_len_illegal, addr_len_field};
         default: port_view = {retry_delay_field, retry_count_field};
      endcase
   endfunction
   task automatic wr(input [4:0] a, input [7:0] d);
      rcrb_host_model_i.xfer({`RCRB_CMD_WRITE, a}, d, rx);
   endtask
   task automatic rd(input [4:0] a);
      rcrb_host_model_i.xfer({`RCRB_CMD_READ, a}, 8'h00, rx);
   endtask
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      for (k = 0; k < 5; k++)
      begin
         rd(k[4:0]);
         `CHK("reset value", rstv[k], rx[7:0])
      end
      `CHK("idle status", 8'h0B, rx[15:8])
      $display("test reset done");
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial
   begin
      #1000000;
      bad_count++;
      finish_test;
   end
   initial
   begin
      do_reset;
      for (i = 0; i < 12; i++)
      begin
         wr(rows[i].a, rows[i].wd);
         `CHK("port view", rows[i].pv, port_view(rows[i].a))
         rd(rows[i].a);
         `CHK("read back", rows[i].rd, rx[7:0])
      end
      rd(5'h05);
      `CHK("unmapped read", 8'h00, rx[7:0])
      $display("test table done");
      for (i = 0; i < 3; i++)
      begin
         @(posedge ref_clk);
         ev <= 3'h4 >> i;
         @(posedge ref_clk);
         ev <= 3'h0;
         repeat (3) @(posedge ref_clk);
         `CHK("irq raised", 1'b0, irq_n)
         rd(5'h07);
         `CHK("status flags", {1'b0, 3'h4 >> i, 4'hB}, rx[15:8])
         wr(5'h00, 8'h79);
         `CHK("irq masked", 1'b1, irq_n)
         wr(5'h00, 8'h09);
         `CHK("irq unmasked", 1'b0, irq_n)
         wr(5'h07, 8'h70);
         `CHK("irq cleared", 1'b1, irq_n)
      end
      $display("test interrupt done");
      // an unknown command and an unmapped write change nothing, and a test-space read returns zero
      rcrb_host_model_i.xfer(8'h40, 8'h7E, rx);
      rd(5'h00);
      `CHK("unknown command", 8'h09, rx[7:0])
      wr(5'h05, 8'h3F);
      rd(5'h01);
      `CHK("unmapped write", 8'h21, rx[7:0])
      rd(5'h18);
      `CHK("test space read", 8'h00, rx[7:0])
      @(posedge ref_clk);
      ev <= 3'h5;
      @(posedge ref_clk);
      ev <= 3'h0;
      wr(5'h07, 8'h40);
      rd(5'h07);
      `CHK("one flag cleared", 8'h1B, rx[7:0])
      `CHK("irq still raised", 1'b0, irq_n)
      wr(5'h07, 8'h10);
      `CHK("last flag cleared", 1'b1, irq_n)
      $display("test refusal done");
      do_reset;
      finish_test;
   end
endmodule // rcrb_register_bank_tb
